// ==== ebr_params.svh ====
// Constants for the external bus pin router
// Summary of operation
// - Bit 15 picks receive or sample-rate clock
// - Bits 14:12 parallel mode, 111 reserved
// - Mode 000 gives all pins to host
// - Mode 001 SPI, GPIO, UART, audio2, SDRAM
// - Mode 010 eight GPIO plus SDRAM controls
// - Mode 011 SPI, audio3 and SDRAM controls
// - Mode 100 audio2, UART and SDRAM controls
// - Mode 101 SPI, UART and SDRAM controls
// - Mode 110 SPI, audio2/3, GPIO, SDRAM controls
// - Bits 11:10 00 routes card port 1
// - Serial-1 mode 01 routes multichannel SPI
// - Serial-1 mode 10 routes GPIO 11:6
// - Bits 9:8 00 routes card port 0
// - Serial-0 mode 01 audio0 plus GPIO 5:4
// - Serial-0 mode 10 routes GPIO 5:0
// - Serial-0 mode 11 routes buffered serial port
// - Bits 7:6 read-only, writes ignored
// - New routing applies on next clock
`ifndef EBR_PARAMS_SVH
`define EBR_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define EBR_SEL_OFFSET   12'h000
`define EBR_ADDR_W       12
`define EBR_CLKSEL_BIT   15
`define EBR_PP_MSB       14
`define EBR_PP_LSB       12
`define EBR_SP1_MSB      11
`define EBR_SP1_LSB      10
`define EBR_SP0_MSB      9
`define EBR_SP0_LSB      8
`define EBR_CLKSEL_RST   1'h0
`define EBR_PP_RST       3'h1
`define EBR_SP_RST       2'h0
`define EBR_RESP_OKAY    2'h0
`define EBR_RESP_SLVERR  2'h2

// ----------------------------------------------------------------
// Mode encodings
// ----------------------------------------------------------------
`define EBR_PP_HOST      3'h0
`define EBR_PP_MIX1      3'h1
`define EBR_PP_GPIO      3'h2
`define EBR_PP_SPI_A3    3'h3
`define EBR_PP_A2_UART   3'h4
`define EBR_PP_SPI_UART  3'h5
`define EBR_PP_MIX6      3'h6
`define EBR_SP_CARD      2'h0
`define EBR_SP_ALT1      2'h1
`define EBR_SP_GPIO      2'h2
`define EBR_SP_ALT3      2'h3
`define EBR_PP_SDRAM_LSB 21

`endif

// ==== ebr_pin_router.sv ====
// External bus select register and pin routing with AXI4-Lite access
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "ebr_params.svh"

module ebr_pin_router
  import ebr_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [27:0] pp_pin_in,
  output var  logic [27:0] pp_pin_out,
  output var  logic [27:0] pp_pin_oe,
  input  wire logic [5:0]  sp0_pin_in,
  output var  logic [5:0]  sp0_pin_out,
  output var  logic [5:0]  sp0_pin_oe,
  input  wire logic [5:0]  sp1_pin_in,
  output var  logic [5:0]  sp1_pin_out,
  output var  logic [5:0]  sp1_pin_oe,
  input  wire logic [27:0] host_port_out,
  input  wire logic [27:0] host_port_oe,
  output var  logic [27:0] host_port_in,
  input  wire logic [6:0]  spi_out,
  input  wire logic [6:0]  spi_oe,
  output var  logic [6:0]  spi_in,
  input  wire logic [7:0]  pp_gpio_out,
  input  wire logic [7:0]  pp_gpio_oe,
  output var  logic [7:0]  pp_gpio_in,
  input  wire logic [3:0]  uart_out,
  input  wire logic [3:0]  uart_oe,
  output var  logic [3:0]  uart_in,
  input  wire logic [3:0]  audio_port_2_out,
  input  wire logic [3:0]  audio_port_2_oe,
  output var  logic [3:0]  audio_port_2_in,
  input  wire logic [3:0]  audio_port_3_out,
  input  wire logic [3:0]  audio_port_3_oe,
  output var  logic [3:0]  audio_port_3_in,
  input  wire logic [6:0]  sdram_ctl_out,
  input  wire logic [6:0]  sdram_ctl_oe,
  output var  logic [6:0]  sdram_ctl_in,
  input  wire logic [5:0]  card_port_0_out,
  input  wire logic [5:0]  card_port_0_oe,
  output var  logic [5:0]  card_port_0_in,
  input  wire logic [3:0]  audio_port_0_out,
  input  wire logic [3:0]  audio_port_0_oe,
  output var  logic [3:0]  audio_port_0_in,
  input  wire logic [5:0]  general_io_line_lo_out,
  input  wire logic [5:0]  general_io_line_lo_oe,
  output var  logic [5:0]  general_io_line_lo_in,
  input  wire logic [5:0]  msp_out,
  input  wire logic [5:0]  msp_oe,
  output var  logic [5:0]  msp_in,
  output var  logic        msp_sample_rate_clock,
  input  wire logic [5:0]  card_port_1_out,
  input  wire logic [5:0]  card_port_1_oe,
  output var  logic [5:0]  card_port_1_in,
  input  wire logic [5:0]  multichannel_spi_out,
  input  wire logic [5:0]  multichannel_spi_oe,
  output var  logic [5:0]  multichannel_spi_in,
  input  wire logic [5:0]  general_io_line_hi_out,
  input  wire logic [5:0]  general_io_line_hi_oe,
  output var  logic [5:0]  general_io_line_hi_in
);

  // ----------------------------------------------------------------
  // Routing functions, shared by the data and enable paths
  // ----------------------------------------------------------------
  function automatic ebr_pp_pins_type pp_mux(
    input ebr_pp_mode_type mode,
    input logic [27:0]     host,
    input logic [6:0]      spi,
    input logic [7:0]      gpio,
    input logic [3:0]      uart,
    input logic [3:0]      a2,
    input logic [3:0]      a3,
    input logic [6:0]      sdram
  );
    ebr_pp_pins_type p;
    p = '0;
    unique case (mode)
      `EBR_PP_HOST:      p = host;
      `EBR_PP_MIX1:      p = {sdram, a2, uart, gpio[5:0], spi};
      `EBR_PP_GPIO:      p = {sdram, 13'h0000, gpio};
      `EBR_PP_SPI_A3:    p = {sdram, 13'h0000, a3, spi[3:0]};
      `EBR_PP_A2_UART:   p = {sdram, 13'h0000, uart, a2};
      `EBR_PP_SPI_UART:  p = {sdram, 13'h0000, uart, spi[3:0]};
      `EBR_PP_MIX6:      p = {sdram, gpio[5:0], a3, a2, spi};
      default:           p = '0;  // Reserved 111 drives nothing
    endcase
    return p;
  endfunction

  // Pin 3 doubles as the receive clock or the sample-rate clock input
  function automatic ebr_sp_pins_type sp0_mux(
    input ebr_sp_mode_type mode,
    input logic            clk_sel,
    input logic [5:0]      card,
    input logic [3:0]      a0,
    input logic [5:0]      gpio,
    input logic [5:0]      msp
  );
    ebr_sp_pins_type p;
    p = '0;
    unique case (mode)
      `EBR_SP_CARD: p = card;
      `EBR_SP_ALT1: p = {gpio[5:4], a0};
      `EBR_SP_GPIO: p = gpio;
      `EBR_SP_ALT3: p = {msp[5:4], msp[3] & ~clk_sel, msp[2:0]};
    endcase
    return p;
  endfunction

  function automatic ebr_sp_pins_type sp1_mux(
    input ebr_sp_mode_type mode,
    input logic [5:0]      card,
    input logic [5:0]      mspi,
    input logic [5:0]      gpio
  );
    ebr_sp_pins_type p;
    p = '0;
    unique case (mode)
      `EBR_SP_CARD: p = card;
      `EBR_SP_ALT1: p = mspi;
      `EBR_SP_GPIO: p = gpio;
      `EBR_SP_ALT3: p = '0;     // Reserved, nothing driven
    endcase
    return p;
  endfunction

  // ----------------------------------------------------------------
  // Bus select register fields
  // ----------------------------------------------------------------
  logic            clk_sel_q;
  ebr_pp_mode_type parallel_port_mode_q;
  ebr_sp_mode_type serial_port1_mode_q;
  ebr_sp_mode_type serial_port0_mode_q;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic        aw_full_q;
  logic        w_full_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  wire         aw_take    = s_axi_awvalid & s_axi_awready;
  wire         w_take     = s_axi_wvalid & s_axi_wready;
  wire         aw_full_d  = aw_full_q | aw_take;
  wire         w_full_d   = w_full_q | w_take;
  wire [11:0]  wr_addr    = aw_full_q ? awaddr_q : s_axi_awaddr;
  wire [31:0]  wr_data    = w_full_q ? wdata_q : s_axi_wdata;
  wire [3:0]   wr_strb    = w_full_q ? wstrb_q : s_axi_wstrb;
  wire         wr_commit  = aw_full_d & w_full_d & ~s_axi_bvalid;
  wire         wr_hit     = {wr_addr[11:2], 2'h0} == `EBR_SEL_OFFSET;
  // Only the upper byte holds writable fields; bits 7:6 are ignored
  wire         wr_upper   = wr_commit & wr_hit & wr_strb[1];
  wire         bvalid_d   = wr_commit | (s_axi_bvalid & ~s_axi_bready);
  wire         aw_hold_d  = aw_full_d & ~wr_commit;
  wire         w_hold_d   = w_full_d & ~wr_commit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      awaddr_q      <= 12'h000;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `EBR_RESP_OKAY;
    end else begin
      aw_full_q     <= aw_hold_d;
      w_full_q      <= w_hold_d;
      awaddr_q      <= wr_addr;
      wdata_q       <= wr_data;
      wstrb_q       <= wr_strb;
      s_axi_awready <= ~aw_hold_d & ~bvalid_d;
      s_axi_wready  <= ~w_hold_d & ~bvalid_d;
      s_axi_bvalid  <= bvalid_d;
      if (wr_commit) begin
        s_axi_bresp <= wr_hit ? `EBR_RESP_OKAY : `EBR_RESP_SLVERR;
      end
    end
  end

  // Fields take effect at the commit edge; pins follow one edge later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_sel_q            <= `EBR_CLKSEL_RST;
      parallel_port_mode_q <= `EBR_PP_RST;
      serial_port1_mode_q  <= `EBR_SP_RST;
      serial_port0_mode_q  <= `EBR_SP_RST;
    end else if (wr_upper) begin
      clk_sel_q            <= wr_data[`EBR_CLKSEL_BIT];
      parallel_port_mode_q <= wr_data[`EBR_PP_MSB:`EBR_PP_LSB];
      serial_port1_mode_q  <= wr_data[`EBR_SP1_MSB:`EBR_SP1_LSB];
      serial_port0_mode_q  <= wr_data[`EBR_SP0_MSB:`EBR_SP0_LSB];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  wire        rd_take  = s_axi_arvalid & s_axi_arready;
  wire        rd_hit   = {s_axi_araddr[11:2], 2'h0} == `EBR_SEL_OFFSET;
  // Reserved bits 7:6 and the unmodelled low bits read as zero
  wire [31:0] rd_value = {16'h0000, clk_sel_q, parallel_port_mode_q,
                          serial_port1_mode_q, serial_port0_mode_q,
                          8'h00};
  wire        rvalid_d = rd_take | (s_axi_rvalid & ~s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `EBR_RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid  <= rvalid_d;
      if (rd_take) begin
        s_axi_rdata <= rd_hit ? rd_value : 32'h0000_0000;
        s_axi_rresp <= rd_hit ? `EBR_RESP_OKAY : `EBR_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin-side selection
  // ----------------------------------------------------------------
  wire ebr_pp_mode_type ppm = parallel_port_mode_q;
  wire ebr_sp_mode_type s0m = serial_port0_mode_q;
  wire ebr_sp_mode_type s1m = serial_port1_mode_q;
  wire [6:0] sd_in = pp_pin_in[27:`EBR_PP_SDRAM_LSB];

  wire [27:0] pp_out_d = pp_mux(ppm, host_port_out, spi_out,
    pp_gpio_out, uart_out, audio_port_2_out, audio_port_3_out,
    sdram_ctl_out);
  wire [27:0] pp_oe_d = pp_mux(ppm, host_port_oe, spi_oe,
    pp_gpio_oe, uart_oe, audio_port_2_oe, audio_port_3_oe,
    sdram_ctl_oe);
  wire [5:0]  sp0_out_d = sp0_mux(s0m, clk_sel_q, card_port_0_out,
    audio_port_0_out, general_io_line_lo_out, msp_out);
  wire [5:0]  sp0_oe_d = sp0_mux(s0m, clk_sel_q, card_port_0_oe,
    audio_port_0_oe, general_io_line_lo_oe, msp_oe);
  wire [5:0]  sp1_out_d = sp1_mux(s1m, card_port_1_out,
    multichannel_spi_out, general_io_line_hi_out);
  wire [5:0]  sp1_oe_d = sp1_mux(s1m, card_port_1_oe,
    multichannel_spi_oe, general_io_line_hi_oe);

  // Inputs reach only the peripheral that owns the pin; others see 0
  wire [27:0] host_in_d = (ppm == `EBR_PP_HOST) ? pp_pin_in : '0;
  wire [6:0]  spi_in_d =
    (ppm == `EBR_PP_MIX1 || ppm == `EBR_PP_MIX6) ? pp_pin_in[6:0] :
    (ppm == `EBR_PP_SPI_A3 || ppm == `EBR_PP_SPI_UART) ?
      {3'h0, pp_pin_in[3:0]} : '0;
  wire [7:0]  gpio_in_d =
    (ppm == `EBR_PP_MIX1) ? {2'h0, pp_pin_in[12:7]} :
    (ppm == `EBR_PP_GPIO) ? pp_pin_in[7:0] :
    (ppm == `EBR_PP_MIX6) ? {2'h0, pp_pin_in[27:22] & 6'h00} |
                            {2'h0, pp_pin_in[20:15]} : '0;
  wire [3:0]  uart_in_d =
    (ppm == `EBR_PP_MIX1) ? pp_pin_in[16:13] :
    (ppm == `EBR_PP_A2_UART || ppm == `EBR_PP_SPI_UART) ?
      pp_pin_in[7:4] : '0;
  wire [3:0]  a2_in_d =
    (ppm == `EBR_PP_MIX1)    ? pp_pin_in[20:17] :
    (ppm == `EBR_PP_A2_UART) ? pp_pin_in[3:0] :
    (ppm == `EBR_PP_MIX6)    ? pp_pin_in[10:7] : '0;
  wire [3:0]  a3_in_d =
    (ppm == `EBR_PP_SPI_A3) ? pp_pin_in[7:4] :
    (ppm == `EBR_PP_MIX6)   ? pp_pin_in[14:11] : '0;
  // Host mode displaces the SDRAM controls
  wire        sd_on = ppm != `EBR_PP_HOST && ppm != 3'h7;
  wire [6:0]  sd_in_d = sd_on ? sd_in : '0;
  wire        msp_on = s0m == `EBR_SP_ALT3;
  wire [5:0]  msp_in_d = msp_on ? {sp0_pin_in[5:4],
    sp0_pin_in[3] & ~clk_sel_q, sp0_pin_in[2:0]} : '0;
  wire        srclk_d = msp_on & clk_sel_q & sp0_pin_in[3];
  wire [5:0]  glo_in_d =
    (s0m == `EBR_SP_GPIO) ? sp0_pin_in :
    (s0m == `EBR_SP_ALT1) ? {sp0_pin_in[5:4], 4'h0} : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pp_pin_out  <= '0;
      pp_pin_oe   <= '0;
      sp0_pin_out <= '0;
      sp0_pin_oe  <= '0;
      sp1_pin_out <= '0;
      sp1_pin_oe  <= '0;
    end else begin
      pp_pin_out  <= pp_out_d;
      pp_pin_oe   <= pp_oe_d;
      sp0_pin_out <= sp0_out_d;
      sp0_pin_oe  <= sp0_oe_d;
      sp1_pin_out <= sp1_out_d;
      sp1_pin_oe  <= sp1_oe_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_port_in          <= '0;
      spi_in                <= '0;
      pp_gpio_in            <= '0;
      uart_in               <= '0;
      audio_port_2_in       <= '0;
      audio_port_3_in       <= '0;
      sdram_ctl_in          <= '0;
      card_port_0_in        <= '0;
      audio_port_0_in       <= '0;
      general_io_line_lo_in <= '0;
      msp_in                <= '0;
      msp_sample_rate_clock <= 1'b0;
      card_port_1_in        <= '0;
      multichannel_spi_in   <= '0;
      general_io_line_hi_in <= '0;
    end else begin
      host_port_in          <= host_in_d;
      spi_in                <= spi_in_d;
      pp_gpio_in            <= gpio_in_d;
      uart_in               <= uart_in_d;
      audio_port_2_in       <= a2_in_d;
      audio_port_3_in       <= a3_in_d;
      sdram_ctl_in          <= sd_in_d;
      card_port_0_in        <= (s0m == `EBR_SP_CARD) ? sp0_pin_in : '0;
      audio_port_0_in       <= (s0m == `EBR_SP_ALT1) ?
                               sp0_pin_in[3:0] : '0;
      general_io_line_lo_in <= glo_in_d;
      msp_in                <= msp_in_d;
      msp_sample_rate_clock <= srclk_d;
      card_port_1_in        <= (s1m == `EBR_SP_CARD) ? sp1_pin_in : '0;
      multichannel_spi_in   <= (s1m == `EBR_SP_ALT1) ?
                               sp1_pin_in : '0;
      general_io_line_hi_in <= (s1m == `EBR_SP_GPIO) ?
                               sp1_pin_in : '0;
    end
  end

endmodule // ebr_pin_router

`default_nettype wire

// ==== ebr_pin_router_checker.sv ====
// Assertion checker for the external bus pin router
`timescale 1ns/10ps
`default_nettype none
module ebr_pin_router_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic [27:0] pp_pin_out,
  input wire logic [27:0] pp_pin_oe,
  input wire logic [27:0] host_port_out,
  input wire logic [6:0]  sdram_ctl_out,
  input wire logic [5:0]  sp0_pin_out,
  input wire logic [5:0]  card_port_0_out,
  input wire logic [5:0]  sp0_pin_in,
  input wire logic        msp_sample_rate_clock
);
  // ------------------------------------------------------------
  // Shadow of the mode fields
  // ------------------------------------------------------------
  // Only sees writes whose address and data land on one edge
  logic [7:0] fld_q;
  logic [7:0] fld_p_q;
  logic [1:0] up_q;
  logic       pin3_q;
  wire logic  wr_hit;
  wire logic  live;
  assign wr_hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                  s_axi_wready;
  assign live = (up_q == 2'h3);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fld_q   <= 8'h10;
      fld_p_q <= 8'h10;
      up_q    <= 2'h0;
    end else begin
      if (wr_hit && s_axi_awaddr[11:2] == 10'h000 && s_axi_wstrb[1])
        fld_q <= s_axi_wdata[15:8];
      fld_p_q <= fld_q;
      if (!live) up_q <= up_q + 2'h1;
    end
    pin3_q <= sp0_pin_in[3];
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wr_answer_a: assert property (wr_hit |=> s_axi_bvalid)
    else $error("write response missing one cycle after handshake");
  bad_read_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[11:2] != 10'h000 |=> s_axi_rvalid &&
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  rsv_bits_a: assert property (s_axi_rvalid |->
    s_axi_rdata[7:6] == 2'h0 && s_axi_rdata[31:16] == 16'h0000)
    else $error("reserved read bits not zero");
  host_route_a: assert property (live && fld_p_q[6:4] == 3'h0 |->
    pp_pin_out == $past(host_port_out))
    else $error("host port not on parallel pins");
  sdram_route_a: assert property (live && fld_p_q[6:4] != 3'h0 &&
    fld_p_q[6:4] != 3'h7 |-> pp_pin_out[27:21] == $past(sdram_ctl_out))
    else $error("sdram controls not on parallel pins");
  card0_route_a: assert property (live && fld_p_q[1:0] == 2'h0 |->
    sp0_pin_out == $past(card_port_0_out))
    else $error("card port 0 not on serial port 0");
  clk_select_a: assert property (live && fld_p_q[7] &&
    fld_p_q[1:0] == 2'h3 |-> msp_sample_rate_clock == pin3_q)
    else $error("sample rate clock not taken from shared pin");
  pp_reserved_a: assert property (live && fld_p_q[6:4] == 3'h7 |->
    pp_pin_oe == 28'h000_0000)
    else $error("reserved parallel mode drives pins");
endmodule // ebr_pin_router_checker
bind ebr_pin_router ebr_pin_router_checker chk_u (.*);
`default_nettype wire

// ==== ebr_pin_router_tb.sv ====
// Self-checking bench for the external bus pin router
`timescale 1ns/10ps
`default_nettype none
module ebr_pin_router_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, msp_sample_rate_clock;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [27:0] pp_pin_in, pp_pin_out, pp_pin_oe;
  logic [27:0] host_port_out, host_port_oe, host_port_in;
  logic [6:0]  spi_out, spi_oe, spi_in, sdram_ctl_out, sdram_ctl_oe;
  logic [6:0]  sdram_ctl_in;
  logic [7:0]  pp_gpio_out, pp_gpio_oe, pp_gpio_in;
  logic [3:0]  uart_out, uart_oe, uart_in, audio_port_2_out;
  logic [3:0]  audio_port_2_oe, audio_port_2_in, audio_port_3_out;
  logic [3:0]  audio_port_3_oe, audio_port_3_in, audio_port_0_out;
  logic [3:0]  audio_port_0_oe, audio_port_0_in;
  logic [5:0]  sp0_pin_in, sp0_pin_out, sp0_pin_oe, sp1_pin_in, sp1_pin_out;
  logic [5:0]  sp1_pin_oe, card_port_0_out, card_port_0_oe, card_port_0_in;
  logic [5:0]  general_io_line_lo_out, general_io_line_lo_oe;
  logic [5:0]  general_io_line_lo_in, msp_out, msp_oe, msp_in;
  logic [5:0]  card_port_1_out, card_port_1_oe, card_port_1_in;
  logic [5:0]  multichannel_spi_out, multichannel_spi_oe;
  logic [5:0]  multichannel_spi_in, general_io_line_hi_out;
  logic [5:0]  general_io_line_hi_oe, general_io_line_hi_in;
  int          errors;
  int          n_compared;
  ebr_pin_router dut_u (.*);
  always #4 aclk = ~aclk;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Distinct slices per peripheral so a swapped route shows up
  task automatic drive_pins(input logic [31:0] p);
    logic [255:0] v;
    v = {p, ~p, p * 3, p * 5, p * 7, p ^ 32'h5a5a_a5a5, p * 11, p * 13};
    {host_port_out, host_port_oe, spi_out, spi_oe, pp_gpio_out, pp_gpio_oe,
     uart_out, uart_oe, audio_port_2_out, audio_port_2_oe, audio_port_3_out,
     audio_port_3_oe, sdram_ctl_out, sdram_ctl_oe, card_port_0_out,
     card_port_0_oe, audio_port_0_out, audio_port_0_oe,
     general_io_line_lo_out, general_io_line_lo_oe, msp_out, msp_oe,
     card_port_1_out, card_port_1_oe, multichannel_spi_out,
     multichannel_spi_oe, general_io_line_hi_out, general_io_line_hi_oe,
     pp_pin_in, sp0_pin_in, sp1_pin_in} <= v[243:0];
  endtask
  function automatic logic [27:0] pp_exp(input logic [2:0] m);
    case (m)
      3'h0: pp_exp = host_port_out;
      3'h1: pp_exp = {sdram_ctl_out, audio_port_2_out, uart_out,
                      pp_gpio_out[5:0], spi_out};
      3'h2: pp_exp = {sdram_ctl_out, 13'h0, pp_gpio_out};
      3'h3: pp_exp = {sdram_ctl_out, 13'h0, audio_port_3_out, spi_out[3:0]};
      3'h4: pp_exp = {sdram_ctl_out, 13'h0, uart_out, audio_port_2_out};
      3'h5: pp_exp = {sdram_ctl_out, 13'h0, uart_out, spi_out[3:0]};
      3'h6: pp_exp = {sdram_ctl_out, pp_gpio_out[5:0], audio_port_3_out,
                      audio_port_2_out, spi_out};
      default: pp_exp = 28'h000_0000;
    endcase
  endfunction
  function automatic logic [5:0] sp_exp(input logic [1:0] m, input logic c,
                                         input logic one);
    if (one) begin
      sp_exp = (m == 2'h0) ? card_port_1_out : (m == 2'h1) ?
               multichannel_spi_out : (m == 2'h2) ? general_io_line_hi_out :
               6'h00;
    end else begin
      sp_exp = (m == 2'h0) ? card_port_0_out : (m == 2'h1) ?
               {general_io_line_lo_out[5:4], audio_port_0_out} :
               (m == 2'h2) ? general_io_line_lo_out :
               (c ? (msp_out & 6'h37) : msp_out);
    end
  endfunction
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    r = 2'h3;
    d = 32'hffff_ffff;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_reset;
    logic [31:0] rd;
    logic [1:0]  r;
    axi_rd(12'h000, rd, r);
    check("reset value", rd, 32'h0000_1000);
    check("reset resp", r, 2'h0);
    $display("reset test done");
  endtask
  // All eight parallel codes, every serial code, both clock choices
  task automatic test_modes;
    logic [2:0]  m;
    logic [31:0] w;
    logic [31:0] rd;
    logic [1:0]  r;
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      w = {16'h0000, m[2], m, m[1:0], ~m[1:0], 8'hff};
      @(posedge aclk);
      drive_pins(32'h9e37_79b9 * (i + 1));
      axi_wr(12'h000, w, 4'hf, r);
      check("write resp", r, 2'h0);
      axi_rd(12'h000, rd, r);
      check("readback", rd, {w[31:8], 8'h00});
      @(posedge aclk);
      check("pp pins", pp_pin_out, pp_exp(m));
      check("sp1 pins", sp1_pin_out, sp_exp(m[1:0], 1'b0, 1'b1));
      check("sp0 pins", sp0_pin_out, sp_exp(~m[1:0], m[2], 1'b0));
      check("sdram in", sdram_ctl_in, m == 3'h0 || m == 3'h7 ? 7'h00 :
            pp_pin_in[27:21]);
      check("sp1 in", {card_port_1_in, multichannel_spi_in,
            general_io_line_hi_in}, {m[1:0] == 2'h0 ? sp1_pin_in : 6'h00,
            m[1:0] == 2'h1 ? sp1_pin_in : 6'h00, m[1:0] == 2'h2 ?
            sp1_pin_in : 6'h00});
      check("card0 in", card_port_0_in,
            m[1:0] == 2'h3 ? sp0_pin_in : 6'h00);
      check("msp in", msp_in, m[1:0] != 2'h0 ? 6'h00 :
            sp0_pin_in & {2'h3, ~m[2], 3'h7});
      if (m[1:0] == 2'h3) check("card0 oe", sp0_pin_oe, card_port_0_oe);
      if (m[1:0] == 2'h1) check("mspi oe", sp1_pin_oe, multichannel_spi_oe);
      if (m == 3'h0) begin
        check("host oe", pp_pin_oe, host_port_oe);
        check("host in", host_port_in, pp_pin_in);
      end
      check("clk", msp_sample_rate_clock, (m == 3'h4) & sp0_pin_in[3]);
      $display("mode set %0d done", i);
    end
  endtask
  task automatic test_refuse;
    logic [31:0] rd;
    logic [1:0]  r;
    axi_wr(12'h004, 32'h0000_0000, 4'hf, r);
    check("unmapped write resp", r, 2'h2);
    axi_wr(12'h000, 32'h0000_0000, 4'hd, r);
    check("lane off resp", r, 2'h0);
    axi_rd(12'h000, rd, r);
    check("unchanged", rd, 32'h0000_fc00);
    axi_rd(12'h008, rd, r);
    check("unmapped read resp", r, 2'h2);
    check("unmapped read data", rd, 32'h0000_0000);
    do_reset;
    test_reset;
    $display("refusal test done");
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    errors = 0;
    n_compared = 0;
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb,
     s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot, s_axi_arvalid,
     s_axi_rready} = 71'h0;
    drive_pins(32'h0000_0001);
    do_reset;
    test_reset;
    test_modes;
    test_refuse;
    give_verdict;
  end
  // Whole run is about a hundred cycles
  initial begin
    #(3000 * 8);
    errors++;
    give_verdict;
  end
endmodule // ebr_pin_router_tb
`default_nettype wire

// ==== ebr_pkg.sv ====
// Types shared by the external bus pin router
package ebr_pkg;
  typedef logic [2:0]  ebr_pp_mode_type;
  typedef logic [1:0]  ebr_sp_mode_type;
  typedef logic [27:0] ebr_pp_pins_type;
  typedef logic [5:0]  ebr_sp_pins_type;
endpackage
